// >>> verilog/cwo_compare_waveform_output.sv
// Eight-channel output-compare waveform generator with APB registers
//
// Functional notes
// - Phase-delayed output toggles on each compare match.
// - No reset select: timer free-runs 65536 counts.
// - Channel-0 reset bit clears timer on ch0.
// - Reload reset bit clears timer on reload.
// - Phase-delayed period is 2(n+2) cycles.
// - Function-enable bit starts and stops output.
// - Phase-delayed match sets channel match flag.
// - Software selects the starting output level.
// - Polarity flip inverts the output pin.
// - Set/reset even match drives output high.
// - Set/reset odd match returns output low.
// - Set/reset period 65536 or p+2 counts.
// - Pair starts both enabled, stops both cleared.
// - Each pair match sets its own flag.
// - Set/reset waveform only on even pins.
// - Two-bit field selects the waveform kind.
// - Function select zero makes channel a generator.
// - Odd pin of a set/reset pair released.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module cwo_compare_waveform_output (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  waveform_out_pin,
  output logic      [7:0]  odd_pin_released
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0]                count,        next_count;
  logic                       rst_pend,     next_rst_pend;
  cwo_pkg::cwo_rsel_type      rsel,         next_rsel;
  logic [15:0]                reload,       next_reload;
  logic [7:0]                 fen,          next_fen;
  logic [7:0]                 fsel,         next_fsel;
  logic [7:0]                 fen_q,        next_fen_q;
  logic [7:0]                 flag,         next_flag;
  logic [7:0]                 wave,         next_wave;
  logic [7:0]                 pin,          next_pin;
  logic [7:0]                 rel,          next_rel;
  logic [3:0]                 sr_run,       next_sr_run;
  logic [15:0]                cmp   [8],    next_cmp [8];
  cwo_pkg::cwo_chctl_type     ctl   [8],    next_ctl [8];
  logic [31:0]                rdata,        next_rdata;
  logic [7:0]                 match;
  logic [7:0]                 active;
  logic                       setup;
  logic                       wr;
  logic                       mapped;
  logic [2:0]                 idx;

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign idx    = paddr[cwo_pkg::CWO_IDX_LSB +: cwo_pkg::CWO_IDX_W];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata;
  assign waveform_out_pin = pin;
  assign odd_pin_released = rel;

  // ----------------------------------------
  // Match and channel qualification
  // ----------------------------------------
  always_comb begin
    for (int j = 0; j < cwo_pkg::CWO_NCH; j++) begin
      match[j]  = (count == cmp[j]);
      active[j] = fen[j] && !fsel[j];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    int e;
    logic pair_sr;
    e             = 0;
    pair_sr       = 1'b0;
    next_rsel     = rsel;
    next_reload   = reload;
    next_fen      = fen;
    next_fsel     = fsel;
    next_fen_q    = fen;
    next_flag     = flag;
    next_wave     = wave;
    next_pin      = pin;
    next_rel      = rel;
    next_sr_run   = sr_run;
    next_rdata    = rdata;
    next_cmp      = cmp;
    next_ctl      = ctl;
    mapped        = 1'b1;

    // Register access decode
    if ((paddr & cwo_pkg::CWO_BANK_MASK) == cwo_pkg::CWO_OFF_CMP) begin
      next_rdata = {16'h0000, cmp[idx]};
      if (wr) begin
        next_cmp[idx] = pwdata[15:0];
      end
    end else if ((paddr & cwo_pkg::CWO_BANK_MASK) == cwo_pkg::CWO_OFF_CHCTL) begin
      next_rdata = {28'h0000000, ctl[idx]};
      if (wr) begin
        next_ctl[idx] = pwdata[3:0];
      end
    end else if (paddr == cwo_pkg::CWO_OFF_CTRL) begin
      next_rdata = {29'h00000000, rsel};
      if (wr) begin
        next_rsel = pwdata[2:0];
      end
    end else if (paddr == cwo_pkg::CWO_OFF_RELOAD) begin
      next_rdata = {16'h0000, reload};
      if (wr) begin
        next_reload = pwdata[15:0];
      end
    end else if (paddr == cwo_pkg::CWO_OFF_FUNC_EN) begin
      next_rdata = {16'h0000, fsel, fen};
      if (wr) begin
        next_fen  = pwdata[7:0];
        next_fsel = pwdata[cwo_pkg::CWO_FSEL_LSB +: 8];
      end
    end else if (paddr == cwo_pkg::CWO_OFF_FLAG) begin
      next_rdata = {24'h000000, flag};
      if (wr) begin
        next_flag = flag & ~pwdata[7:0];
      end
    end else if (paddr == cwo_pkg::CWO_OFF_COUNT) begin
      next_rdata = {16'h0000, count};
    end else begin
      next_rdata = cwo_pkg::CWO_WORD_ZERO;
      mapped     = 1'b0;
    end
    if (!setup) begin
      next_rdata = rdata;
    end

    // Per-channel waveform logic
    for (int j = 0; j < cwo_pkg::CWO_NCH; j++) begin
      e       = j - (j % 2);
      pair_sr = (ctl[e].waveform_kind_select == cwo_pkg::CWO_KIND_SR);
      if (active[j] && match[j]) begin
        next_flag[j] = 1'b1;
      end
      if (pair_sr && (j % 2 == 0)) begin
        if (!sr_run[j/2] && active[j] && active[j+1]) begin
          next_sr_run[j/2] = 1'b1;
          next_wave[j]     = ctl[j].default_level_select;
        end else if (sr_run[j/2] && !active[j] && !active[j+1]) begin
          next_sr_run[j/2] = 1'b0;
        end else if (sr_run[j/2] && match[j+1]) begin
          next_wave[j] = 1'b0;
        end else if (sr_run[j/2] && match[j]) begin
          next_wave[j] = 1'b1;
        end
      end else if (!pair_sr) begin
        if (active[j] && !fen_q[j]) begin
          next_wave[j] = ctl[j].default_level_select;
        end else if (active[j] &&
                     ctl[j].waveform_kind_select == cwo_pkg::CWO_KIND_PHASE) begin
          if (match[j]) begin
            next_wave[j] = !wave[j];
          end
        end else if (active[j] &&
                     ctl[j].waveform_kind_select == cwo_pkg::CWO_KIND_SINGLE) begin
          if (match[j]) begin
            next_wave[j] = !ctl[j].default_level_select;
          end else if (count == cwo_pkg::CWO_CNT_RST) begin
            next_wave[j] = ctl[j].default_level_select;
          end
        end
      end
      // odd pin idle in a pair
      next_rel[j] = pair_sr && (j % 2 == 1);
      next_pin[j] = next_rel[j] ? 1'b0 :
                    (next_wave[j] ^ next_ctl[j].polarity_flip);
    end
  end

  // ----------------------------------------
  // Base timer
  // ----------------------------------------
  // Clear lands one count after the match, giving the n+2 period
  always_comb begin
    next_rst_pend = 1'b0;
    if (rsel == cwo_pkg::CWO_RSEL_CH0) begin
      next_rst_pend = (count == cmp[0]);
    end else if (rsel == cwo_pkg::CWO_RSEL_RELOAD) begin
      next_rst_pend = (count == reload);
    end
    if (rst_pend) begin
      next_count = cwo_pkg::CWO_CNT_RST;
    end else begin
      next_count = count + cwo_pkg::CWO_CNT_ONE;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= cwo_pkg::CWO_CNT_RST;
      rst_pend <= 1'b0;
      rsel     <= cwo_pkg::CWO_RSEL_RST;
      reload   <= cwo_pkg::CWO_RELOAD_RST;
      fen      <= '0;
      fsel     <= '0;
      fen_q    <= '0;
      flag     <= '0;
      wave     <= '0;
      pin      <= '0;
      rel      <= '0;
      sr_run   <= '0;
      rdata    <= cwo_pkg::CWO_WORD_ZERO;
      for (int j = 0; j < cwo_pkg::CWO_NCH; j++) begin
        cmp[j] <= cwo_pkg::CWO_CMP_RST;
        ctl[j] <= cwo_pkg::CWO_CHCTL_RST;
      end
    end else begin
      count    <= next_count;
      rst_pend <= next_rst_pend;
      rsel     <= next_rsel;
      reload   <= next_reload;
      fen      <= next_fen;
      fsel     <= next_fsel;
      fen_q    <= next_fen_q;
      flag     <= next_flag;
      wave     <= next_wave;
      pin      <= next_pin;
      rel      <= next_rel;
      sr_run   <= next_sr_run;
      rdata    <= next_rdata;
      cmp      <= next_cmp;
      ctl      <= next_ctl;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ph0;
  logic sr2;
  assign ph0 = active[0] && fen_q[0] &&
               ctl[0].waveform_kind_select == cwo_pkg::CWO_KIND_PHASE;
  // Pair 2/3 watched: pair 0/1 is lost whenever channel 0 clears the timer
  assign sr2 = sr_run[1] && active[2] && active[3] &&
               ctl[2].waveform_kind_select == cwo_pkg::CWO_KIND_SR;

  sequence s_ch0_hit;
    rsel == cwo_pkg::CWO_RSEL_CH0 && count == cmp[0];
  endsequence
  sequence s_reload_hit;
    rsel == cwo_pkg::CWO_RSEL_RELOAD && count == reload;
  endsequence

  property p_pd_toggle;
    ph0 && match[0] |=> wave[0] != $past(wave[0]);
  endproperty
  a_pd_toggle: assert property (p_pd_toggle) else $error("phase toggle missed");

  property p_free_wrap;
    rsel == cwo_pkg::CWO_RSEL_FREE && !rst_pend && count == 16'hFFFF |=> count == 16'h0000;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("free run wrap wrong");

  property p_ch0_clear;
    s_ch0_hit ##1 rsel == cwo_pkg::CWO_RSEL_CH0 |=> count == 16'h0000;
  endproperty
  a_ch0_clear: assert property (p_ch0_clear) else $error("ch0 clear missed");

  property p_reload_clear;
    s_reload_hit |=> (count == $past(reload) + 16'h0001) ##1 count == 16'h0000;
  endproperty
  a_reload_clear: assert property (p_reload_clear) else $error("reload clear wrong");

  property p_flag_set;
    active[2] && match[2] |=> flag[2];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match flag not set");

  property p_default_load;
    active[0] && !fen_q[0] && ctl[0].waveform_kind_select != cwo_pkg::CWO_KIND_SR
      |=> wave[0] == $past(ctl[0].default_level_select);
  endproperty
  a_default_load: assert property (p_default_load) else $error("default level not loaded");

  property p_polarity;
    !rel[2] |-> pin[2] == (wave[2] ^ ctl[2].polarity_flip);
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

  property p_sr_set;
    sr2 && match[2] && !match[3] |=> wave[2] && pin[2] != ctl[2].polarity_flip;
  endproperty
  a_sr_set: assert property (p_sr_set) else $error("sr set missed");

  property p_sr_clear;
    sr2 && match[3] |=> !wave[2];
  endproperty
  a_sr_clear: assert property (p_sr_clear) else $error("sr clear missed");

  property p_odd_pin;
    ctl[2].waveform_kind_select == cwo_pkg::CWO_KIND_SR |=> rel[3] && !pin[3];
  endproperty
  a_odd_pin: assert property (p_odd_pin) else $error("odd pin not released");

  property p_fsel_block;
    fsel[5] && !(wr && paddr == cwo_pkg::CWO_OFF_FLAG) |=> flag[5] == $past(flag[5]);
  endproperty
  a_fsel_block: assert property (p_fsel_block) else $error("selected-off channel flagged");

endmodule

`default_nettype wire

// >>> verilog/cwo_pkg.sv
// Constants, register map and field layouts of the compare waveform block
package cwo_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int CWO_NCH   = 8;
  localparam int CWO_NPAIR = 4;
  localparam int CWO_CNT_W = 16;
  localparam int CWO_ADR_W = 8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CWO_OFF_CTRL    = 8'h00;
  localparam logic [7:0] CWO_OFF_RELOAD  = 8'h04;
  localparam logic [7:0] CWO_OFF_FUNC_EN = 8'h08;
  localparam logic [7:0] CWO_OFF_FLAG    = 8'h0C;
  localparam logic [7:0] CWO_OFF_COUNT   = 8'h10;
  localparam logic [7:0] CWO_OFF_CMP     = 8'h20;
  localparam logic [7:0] CWO_OFF_CHCTL   = 8'h40;
  localparam logic [7:0] CWO_BANK_MASK   = 8'hE0;
  localparam int         CWO_IDX_LSB     = 2;
  localparam int         CWO_IDX_W       = 3;
  localparam int         CWO_FSEL_LSB    = 8;

  // ----------------------------------------
  // Waveform kinds
  // ----------------------------------------
  localparam logic [1:0] CWO_KIND_SINGLE = 2'h0;
  localparam logic [1:0] CWO_KIND_PHASE  = 2'h1;
  localparam logic [1:0] CWO_KIND_SR     = 2'h2;

  // ----------------------------------------
  // Reset select codes
  // ----------------------------------------
  localparam logic [2:0] CWO_RSEL_FREE   = 3'h0;
  localparam logic [2:0] CWO_RSEL_CH0    = 3'h1;
  localparam logic [2:0] CWO_RSEL_RELOAD = 3'h4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CWO_CNT_RST    = 16'h0000;
  localparam logic [15:0] CWO_CNT_ONE    = 16'h0001;
  localparam logic [15:0] CWO_CMP_RST    = 16'h0000;
  localparam logic [15:0] CWO_RELOAD_RST = 16'hFFFF;
  localparam logic [31:0] CWO_WORD_ZERO  = 32'h0000_0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       reset_on_reload_match;
    logic       reset_select_mid;
    logic       reset_on_ch0_match;
  } cwo_rsel_type;

  typedef struct packed {
    logic       polarity_flip;
    logic       default_level_select;
    logic [1:0] waveform_kind_select;
  } cwo_chctl_type;

  localparam cwo_chctl_type CWO_CHCTL_RST = '0;
  localparam cwo_rsel_type  CWO_RSEL_RST  = '0;

endpackage

// >>> tb/cwo_load_model.sv
// Load model that times the edges seen on each waveform pin
`timescale 1ns/10ps
`default_nettype none

module cwo_load_model (
  input  wire logic       pclk,
  input  wire logic [7:0] pins
);
  // ----------------------------------------
  // Edge timing, in base timer counts
  // ----------------------------------------
  logic [31:0] cyc;
  logic [31:0] last_rise [8];
  logic [31:0] period    [8];
  logic [31:0] high      [8];
  logic [31:0] rises     [8];
  logic [7:0]  prev;

  initial begin
    cyc  = 32'h0;
    prev = 8'h00;
    for (int i = 0; i < 8; i++) begin
      last_rise[i] = 32'h0;
      period[i]    = 32'h0;
      high[i]      = 32'h0;
      rises[i]     = 32'h0;
    end
  end

  // Pins are registered, so the edge sees the settled level of the last cycle
  always @(posedge pclk) begin
    for (int i = 0; i < 8; i++) begin
      if (pins[i] && !prev[i]) begin
        period[i]    = cyc - last_rise[i];
        last_rise[i] = cyc;
        rises[i]     = rises[i] + 32'h1;
      end
      if (!pins[i] && prev[i]) begin
        high[i] = cyc - last_rise[i];
      end
    end
    prev = pins;
    cyc  = cyc + 32'h1;
  end
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the compare waveform block
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end

module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, pins, released;
  logic [31:0] pwdata, prdata, rd, r0, r2;
  logic        err;
  int          fail_count, n_checks, p, q, a, b, c0;

  cwo_compare_waveform_output dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .waveform_out_pin(pins), .odd_pin_released(released));
  cwo_load_model load_u (.pclk(pclk), .pins(pins));

  // ----------------------------------------
  // Clock, reset, bus
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Holds the request until pready is seen high; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] pd_period(int n);
    return 32'(2 * (n + 2));
  endfunction

  function automatic logic [31:0] ctl(logic flip, logic dflt, logic [1:0] kind);
    return {28'h0, flip, dflt, kind};
  endfunction

  task automatic stop_test();
    $display("Checks: %0d  errors: %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    fail_count = 0; n_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0;
    c0 = $urandom(69517);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cwo_pkg::CWO_OFF_RELOAD, 32'h0);
    `CHK("reload reset", 32'h0000FFFF, rd)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    for (int r = 0; r < 2; r++) begin
      // Clear point rises each round, so the running count never overshoots it
      p = 20 + 41 * r + $urandom % 41;
      a = 1 + $urandom % (p / 2);
      b = a + 1 + $urandom % (p - a);
      // Reload reset source, channel 0, 2, 3, 4 and 5 compares kept in range, 1 and 6 set out of reach, channel 3 above channel 2
      apb(1'b1, cwo_pkg::CWO_OFF_CTRL, 32'h4);
      apb(1'b1, cwo_pkg::CWO_OFF_RELOAD, 32'(p));
      apb(1'b1, cwo_pkg::CWO_OFF_CMP, 32'(1 + $urandom % p));
      apb(1'b1, cwo_pkg::CWO_OFF_CMP + 8'h04, 32'h0000FFFD);
      apb(1'b1, cwo_pkg::CWO_OFF_CMP + 8'h08, 32'(a));
      apb(1'b1, cwo_pkg::CWO_OFF_CMP + 8'h0C, 32'(b));
      apb(1'b1, cwo_pkg::CWO_OFF_CMP + 8'h10, 32'(1 + $urandom % p));
      apb(1'b1, cwo_pkg::CWO_OFF_CMP + 8'h14, 32'(1 + $urandom % p));
      apb(1'b1, cwo_pkg::CWO_OFF_CMP + 8'h18, 32'h0000FFFD);
      apb(1'b1, cwo_pkg::CWO_OFF_CHCTL, ctl(1'b0, 1'b0, cwo_pkg::CWO_KIND_PHASE));
      apb(1'b1, cwo_pkg::CWO_OFF_CHCTL + 8'h04, ctl(1'b1, 1'b0, cwo_pkg::CWO_KIND_PHASE));
      apb(1'b1, cwo_pkg::CWO_OFF_CHCTL + 8'h08, ctl(1'b0, 1'b0, cwo_pkg::CWO_KIND_SR));
      apb(1'b1, cwo_pkg::CWO_OFF_CHCTL + 8'h10, ctl(1'b0, 1'b0, cwo_pkg::CWO_KIND_SINGLE));
      apb(1'b1, cwo_pkg::CWO_OFF_CHCTL + 8'h14, ctl(1'b0, 1'b0, cwo_pkg::CWO_KIND_PHASE));
      apb(1'b1, cwo_pkg::CWO_OFF_CHCTL + 8'h18, ctl(1'b0, 1'b1, cwo_pkg::CWO_KIND_PHASE));
      // Channel 5 is not a generator, channels 0 to 6 enabled, channel 7 left off
      apb(1'b1, cwo_pkg::CWO_OFF_FUNC_EN, 32'h0000207F);
      repeat (8 * (p + 2)) @(posedge pclk);
      `CHK("ch0 period", pd_period(p), load_u.period[0])
      `CHK("ch1 flip level", 1'b1, pins[1])
      `CHK("ch6 default level", 1'b1, pins[6])
      `CHK("sr period", 32'(p + 2), load_u.period[2])
      `CHK("sr high width", 32'(b - a), load_u.high[2])
      `CHK("sr odd pin quiet", 32'h0, load_u.rises[3])
      `CHK("sr odd released", 1'b1, released[3])
      `CHK("single period", 32'(p + 2), load_u.period[4])
      `CHK("fsel ch quiet", 32'h0, load_u.rises[5])
      apb(1'b0, cwo_pkg::CWO_OFF_FLAG, 32'h0);
      `CHK("flags set", 32'h1D, rd & 32'h7F)
      apb(1'b1, cwo_pkg::CWO_OFF_FUNC_EN, 32'h0);
      apb(1'b1, cwo_pkg::CWO_OFF_FLAG, 32'h000000FF);
      apb(1'b0, cwo_pkg::CWO_OFF_FLAG, 32'h0);
      `CHK("flags cleared", 32'h0, rd)
      // Taken late: a toggle launched by the last enabled cycle is seen one edge on
      r0 = load_u.rises[0];
      r2 = load_u.rises[2];
      repeat (4 * (p + 2)) @(posedge pclk);
      `CHK("ch0 stopped", r0, load_u.rises[0])
      `CHK("sr stopped", r2, load_u.rises[2])
    end
    // Channel 0 compare as the timer reset source
    q = p + 1 + $urandom % 41;
    apb(1'b1, cwo_pkg::CWO_OFF_CMP, 32'(q));
    apb(1'b1, cwo_pkg::CWO_OFF_CTRL, 32'h1);
    apb(1'b1, cwo_pkg::CWO_OFF_FUNC_EN, 32'h1);
    repeat (8 * (q + 2)) @(posedge pclk);
    `CHK("ch0 reset period", pd_period(q), load_u.period[0])
    // Free run: two count snapshots exactly 65536 cycles apart agree
    apb(1'b1, cwo_pkg::CWO_OFF_CTRL, 32'h0);
    apb(1'b0, cwo_pkg::CWO_OFF_COUNT, 32'h0);
    r0 = rd;
    repeat (65533) @(posedge pclk);
    apb(1'b0, cwo_pkg::CWO_OFF_COUNT, 32'h0);
    `CHK("free run modulus", r0, rd)
    stop_test();
  end
endmodule

`default_nettype wire
